/* verilog/swec_consts.vh */
// Operation
// RULE1 - An overvoltage on the auxiliary supply output sets bit 2 of the supply event flags.
// RULE2 - An undervoltage on the auxiliary supply output sets bit 1 of the supply event flags.
// RULE3 - A drop of the main regulator below its 90 % threshold while it is on sets bit 0.
// RULE4 - Main undervoltage is never captured in Sleep mode and ignores the reset threshold.
// RULE5 - A partial-network frame detection error sets bit 5 of the transceiver event flags.
// RULE6 - Bus silence for the timeout, with detection enabled after activity, sets bit 4.
// RULE7 - Transceiver off by bus-supply undervoltage in mode 01, or TXD clamped, sets bit 1; the code sets it only outside Sleep mode.
// RULE8 - A bus wake-up seen while the transceiver is offline sets bit 0 of its event flags.
// RULE9 - A rising edge on the wake pin sets bit 1 of the wake-pin event flags.
// RULE10 - A falling edge on the wake pin sets bit 0 of the wake-pin event flags.
// RULE11 - Writing one to a flag bit clears it and writing zero leaves it alone.
// RULE12 - Any pending supply, transceiver or wake-pin flag shows as a global summary bit.
// RULE13 - A Sleep command while any flag is pending sends the device to Reset mode instead.
// RULE14 - Flags stay set until cleared by the host, and reserved bits read as zero.
`ifndef SWEC_CONSTS_VH
`define SWEC_CONSTS_VH

// Register addresses
`define SWEC_ADDR_GLOBAL 7'h60
`define SWEC_ADDR_SUPPLY 7'h62
`define SWEC_ADDR_TRX 7'h63
`define SWEC_ADDR_WAKE 7'h64
`define SWEC_ADDR_SUPPLY_EN 7'h1c
`define SWEC_ADDR_TRX_EN 7'h23
`define SWEC_ADDR_WAKE_EN 7'h4c

// Supply flag positions
`define SWEC_BIT_AUX_OVER 2
`define SWEC_BIT_AUX_UNDER 1
`define SWEC_BIT_MAIN_UNDER 0
// Transceiver flag positions
`define SWEC_BIT_PN_ERR 5
`define SWEC_BIT_SILENCE 4
`define SWEC_BIT_CAN_FAIL 1
`define SWEC_BIT_CAN_WAKE 0
// Wake pin flag positions
`define SWEC_BIT_WAKE_RISE 1
`define SWEC_BIT_WAKE_FALL 0
// Global summary positions
`define SWEC_BIT_G_WAKE 3
`define SWEC_BIT_G_TRX 2
`define SWEC_BIT_G_SUPPLY 1
`define SWEC_BIT_G_SYS 0

// Implemented bits per register
`define SWEC_MASK_SUPPLY 8'h07
`define SWEC_MASK_TRX 8'h33
`define SWEC_MASK_WAKE 8'h03
`define SWEC_MASK_GLOBAL 8'h0f
`define SWEC_MASK_TRX_EN 8'h13

// Reset values
`define SWEC_RST_FLAGS 8'h00
`define SWEC_RST_ENABLES 8'h00
`define SWEC_RST_RDATA 8'h00

// Mode codes
`define SWEC_MODE_SLEEP 3'h1
`define SWEC_TRX_MODE_ACTIVE 2'h1

// Bus silence timeout
// Sized so the product fits the timer without truncation
`define SWEC_CLK_MHZ 24'd125
`define SWEC_T_SILENCE_US 24'd1000
`define SWEC_SILENCE_CYCLES (`SWEC_T_SILENCE_US * `SWEC_CLK_MHZ)
`define SWEC_TIMER_W 24

`endif

/* verilog/swec_edge_detect.v */
`timescale 1ns/1ps
`include "swec_consts.vh"

module swec_edge_detect #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Sampled levels
    input wire [W-1:0] level,
    // One-cycle edge pulses
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);
    reg armed;
    reg [W-1:0] prev;

    // No edge on the first sample, a high level at reset is not an event
    always @(posedge clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (!rst_n) begin
                    prev[i] <= 1'b0;
                end else begin
                    prev[i] <= level[i];
                end
            end
            assign rise[i] = armed & level[i] & ~prev[i];
            assign fall[i] = armed & ~level[i] & prev[i];
        end
    endgenerate
endmodule // swec_edge_detect

/* verilog/swec_silence_timer.v */
`timescale 1ns/1ps
`include "swec_consts.vh"

module swec_silence_timer #(
    parameter [`SWEC_TIMER_W-1:0] CYCLES = `SWEC_SILENCE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire enable,
    input wire activity,
    // One-cycle timeout pulse
    output reg timeout
);
    reg was_active;
    reg [`SWEC_TIMER_W-1:0] count;

    // Only a bus that was active can fall silent; one pulse per silence
    always @(posedge clk) begin
        if (!rst_n) begin
            was_active <= 1'b0;
            count <= {`SWEC_TIMER_W{1'b0}};
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (!enable) begin
                was_active <= 1'b0;
                count <= {`SWEC_TIMER_W{1'b0}};
            end else if (activity) begin
                was_active <= 1'b1;
                count <= {`SWEC_TIMER_W{1'b0}};
            end else if (was_active) begin
                if (count == CYCLES - 1'b1) begin
                    timeout <= 1'b1; // RULE6
                    was_active <= 1'b0;
                    count <= {`SWEC_TIMER_W{1'b0}};
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule // swec_silence_timer

/* verilog/swec_event_capture.v */
`timescale 1ns/1ps
`include "swec_consts.vh"

module swec_event_capture #(
    parameter [`SWEC_TIMER_W-1:0] SILENCE_CYCLES = `SWEC_SILENCE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,

    // Register port from the SPI decoder
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,

    // Mode control
    input wire [2:0] device_mode_code,
    input wire mode_wr,
    input wire [2:0] mode_wdata,
    output reg sleep_go,
    output reg reset_go,

    // Supply detectors
    input wire aux_over_det,
    input wire aux_under_det,
    input wire main_under_det,

    // Transceiver detectors
    input wire pn_frame_err_det,
    input wire bus_activity,
    input wire [1:0] transceiver_mode_code,
    input wire vcan_under_off,
    input wire txd_dom_clamp,
    input wire can_wake_det,
    input wire trx_offline,

    // Local wake pin
    input wire wake_pin,

    // System events held elsewhere
    input wire sys_event_pending,

    // Summary
    output wire event_pending
);
    reg [7:0] supply_event_flags;
    reg [7:0] transceiver_event_flags;
    reg [7:0] wake_pin_event_flags;
    reg [7:0] supply_capture_enable;
    reg [7:0] trx_capture_enable;
    reg [7:0] wake_capture_enable;

    reg [7:0] next_supply;
    reg [7:0] next_trx;
    reg [7:0] next_wake;
    reg [7:0] supply_set;
    reg [7:0] trx_set;
    reg [7:0] wake_set;
    reg [7:0] supply_clr;
    reg [7:0] trx_clr;
    reg [7:0] wake_clr;
    reg [7:0] next_rdata;

    wire in_sleep;
    wire bus_silence_enable;
    wire can_fail_cond;
    wire [5:0] cond_level;
    wire [5:0] cond_rise;
    wire wake_rise;
    wire wake_fall;
    wire silence_timeout;
    wire [7:0] global_flags;

    // Main regulator is off in Sleep, so its detector output is meaningless there
    assign in_sleep = (device_mode_code == `SWEC_MODE_SLEEP);

    assign bus_silence_enable = trx_capture_enable[`SWEC_BIT_SILENCE];

    // Undervoltage deactivation only counts while the transceiver was meant to be active
    assign can_fail_cond = ((transceiver_mode_code == `SWEC_TRX_MODE_ACTIVE) &
                            vcan_under_off) | txd_dom_clamp; // RULE7

    // Detector levels, each captured once per assertion
    assign cond_level[0] = aux_over_det;
    assign cond_level[1] = aux_under_det;
    assign cond_level[2] = main_under_det & ~in_sleep; // RULE4
    assign cond_level[3] = pn_frame_err_det;
    assign cond_level[4] = can_fail_cond & ~in_sleep; // RULE7
    assign cond_level[5] = can_wake_det & trx_offline; // RULE8

    swec_edge_detect #(
        .W(6)
    ) u_cond_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(cond_level),
        .rise(cond_rise),
        .fall()
    );

    swec_edge_detect #(
        .W(1)
    ) u_wake_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(wake_pin),
        .rise(wake_rise),
        .fall(wake_fall)
    );

    swec_silence_timer #(
        .CYCLES(SILENCE_CYCLES)
    ) u_silence (
        .clk(clk),
        .rst_n(rst_n),
        .enable(bus_silence_enable),
        .activity(bus_activity),
        .timeout(silence_timeout)
    );

    // Set vectors, gated by the capture enables except the frame error bit
    always @* begin
        supply_set = 8'h00;
        trx_set = 8'h00;
        wake_set = 8'h00;
        supply_set[`SWEC_BIT_AUX_OVER] = cond_rise[0] &
            supply_capture_enable[`SWEC_BIT_AUX_OVER]; // RULE1
        supply_set[`SWEC_BIT_AUX_UNDER] = cond_rise[1] &
            supply_capture_enable[`SWEC_BIT_AUX_UNDER]; // RULE2
        // Fixed 90 % detector; the reset threshold selection is not involved
        supply_set[`SWEC_BIT_MAIN_UNDER] = cond_rise[2] &
            supply_capture_enable[`SWEC_BIT_MAIN_UNDER]; // RULE3
        // Frame detection errors have no enable bit of their own
        trx_set[`SWEC_BIT_PN_ERR] = cond_rise[3]; // RULE5
        trx_set[`SWEC_BIT_SILENCE] = silence_timeout & bus_silence_enable; // RULE6
        trx_set[`SWEC_BIT_CAN_FAIL] = cond_rise[4] &
            trx_capture_enable[`SWEC_BIT_CAN_FAIL]; // RULE7
        trx_set[`SWEC_BIT_CAN_WAKE] = cond_rise[5] &
            trx_capture_enable[`SWEC_BIT_CAN_WAKE]; // RULE8
        wake_set[`SWEC_BIT_WAKE_RISE] = wake_rise &
            wake_capture_enable[`SWEC_BIT_WAKE_RISE]; // RULE9
        wake_set[`SWEC_BIT_WAKE_FALL] = wake_fall &
            wake_capture_enable[`SWEC_BIT_WAKE_FALL]; // RULE10
    end

    // Write-one-to-clear masks
    always @* begin
        supply_clr = 8'h00;
        trx_clr = 8'h00;
        wake_clr = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `SWEC_ADDR_SUPPLY: begin
                    supply_clr = reg_wdata; // RULE11
                end
                `SWEC_ADDR_TRX: begin
                    trx_clr = reg_wdata; // RULE11
                end
                `SWEC_ADDR_WAKE: begin
                    wake_clr = reg_wdata; // RULE11
                end
                // Global summary is read only, writes to it drop
                `SWEC_ADDR_GLOBAL: begin
                    supply_clr = 8'h00;
                end
                default: begin
                    supply_clr = 8'h00;
                end
            endcase
        end
    end

    // A set in the same cycle as its clear wins, so no event is lost
    always @* begin
        next_supply = ((supply_event_flags & ~supply_clr) | supply_set) &
                      `SWEC_MASK_SUPPLY; // RULE14
        next_trx = ((transceiver_event_flags & ~trx_clr) | trx_set) &
                   `SWEC_MASK_TRX; // RULE14
        next_wake = ((wake_pin_event_flags & ~wake_clr) | wake_set) &
                    `SWEC_MASK_WAKE; // RULE14
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            supply_event_flags <= `SWEC_RST_FLAGS;
            transceiver_event_flags <= `SWEC_RST_FLAGS;
            wake_pin_event_flags <= `SWEC_RST_FLAGS;
        end else begin
            supply_event_flags <= next_supply;
            transceiver_event_flags <= next_trx;
            wake_pin_event_flags <= next_wake;
        end
    end

    // Capture enable registers
    always @(posedge clk) begin
        if (!rst_n) begin
            supply_capture_enable <= `SWEC_RST_ENABLES;
            trx_capture_enable <= `SWEC_RST_ENABLES;
            wake_capture_enable <= `SWEC_RST_ENABLES;
        end else if (reg_wr) begin
            case (reg_addr)
                `SWEC_ADDR_SUPPLY_EN: begin
                    supply_capture_enable <= reg_wdata & `SWEC_MASK_SUPPLY;
                end
                `SWEC_ADDR_TRX_EN: begin
                    trx_capture_enable <= reg_wdata & `SWEC_MASK_TRX_EN;
                end
                `SWEC_ADDR_WAKE_EN: begin
                    wake_capture_enable <= reg_wdata & `SWEC_MASK_WAKE;
                end
                `SWEC_ADDR_GLOBAL: begin
                    supply_capture_enable <= supply_capture_enable;
                end
                default: begin
                    wake_capture_enable <= wake_capture_enable;
                end
            endcase
        end
    end

    // Global summary, read only
    assign global_flags[7:4] = 4'h0;
    assign global_flags[`SWEC_BIT_G_WAKE] = |wake_pin_event_flags; // RULE12
    assign global_flags[`SWEC_BIT_G_TRX] = |transceiver_event_flags; // RULE12
    assign global_flags[`SWEC_BIT_G_SUPPLY] = |supply_event_flags; // RULE12
    assign global_flags[`SWEC_BIT_G_SYS] = sys_event_pending;

    assign event_pending = |global_flags; // RULE12

    // Read mux; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `SWEC_ADDR_GLOBAL: begin
                next_rdata = global_flags;
            end
            `SWEC_ADDR_SUPPLY: begin
                next_rdata = supply_event_flags; // RULE14
            end
            `SWEC_ADDR_TRX: begin
                next_rdata = transceiver_event_flags; // RULE14
            end
            `SWEC_ADDR_WAKE: begin
                next_rdata = wake_pin_event_flags; // RULE14
            end
            `SWEC_ADDR_SUPPLY_EN: begin
                next_rdata = supply_capture_enable;
            end
            `SWEC_ADDR_TRX_EN: begin
                next_rdata = trx_capture_enable;
            end
            `SWEC_ADDR_WAKE_EN: begin
                next_rdata = wake_capture_enable;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Read data holds until the next read
    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= `SWEC_RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Sleep request: any pending flag, system ones included, forces Reset
    always @(posedge clk) begin
        if (!rst_n) begin
            sleep_go <= 1'b0;
            reset_go <= 1'b0;
        end else begin
            sleep_go <= 1'b0;
            reset_go <= 1'b0;
            if (mode_wr && mode_wdata == `SWEC_MODE_SLEEP) begin
                if (event_pending) begin
                    reset_go <= 1'b1; // RULE13
                end else begin
                    sleep_go <= 1'b1; // RULE13
                end
            end
        end
    end
endmodule // swec_event_capture

/* tb/swec_event_capture_monitor.sv */
`timescale 1ns/1ps
`include "swec_consts.vh"
module swec_event_capture_monitor #(
    parameter [`SWEC_TIMER_W-1:0] SILENCE_CYCLES = `SWEC_SILENCE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Mode control
    input wire [2:0] device_mode_code,
    input wire mode_wr,
    input wire [2:0] mode_wdata,
    input wire sleep_go,
    input wire reset_go,
    // Detectors
    input wire aux_over_det,
    input wire aux_under_det,
    input wire main_under_det,
    input wire pn_frame_err_det,
    input wire bus_activity,
    input wire [1:0] transceiver_mode_code,
    input wire vcan_under_off,
    input wire txd_dom_clamp,
    input wire can_wake_det,
    input wire trx_offline,
    input wire wake_pin,
    // Summary
    input wire sys_event_pending,
    input wire event_pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire sleep_cmd = mode_wr && (mode_wdata == `SWEC_MODE_SLEEP);
    chk_refuse_sleep: assert property (sleep_cmd && event_pending |=> reset_go && !sleep_go)
        else $error("sleep command not refused");
    chk_accept_sleep: assert property (sleep_cmd && !event_pending |=> sleep_go && !reset_go)
        else $error("sleep command not accepted");
    chk_go_on_cmd: assert property (!sleep_cmd |=> !sleep_go && !reset_go)
        else $error("mode pulse without command");
    chk_supply_reserved: assert property (reg_rd && reg_addr == `SWEC_ADDR_SUPPLY |=>
        (reg_rdata & ~`SWEC_MASK_SUPPLY) == 8'h00) else $error("supply reserved bits set");
    chk_wake_reserved: assert property (reg_rd && reg_addr == `SWEC_ADDR_WAKE |=>
        (reg_rdata & ~`SWEC_MASK_WAKE) == 8'h00) else $error("wake reserved bits set");
    chk_frame_err_pend: assert property ($rose(pn_frame_err_det) && $past(rst_n) |=>
        ##[0:2] event_pending) else $error("frame error not pending");
    chk_flags_sticky: assert property ($fell(event_pending) |->
        $past(reg_wr) || $past(sys_event_pending)) else $error("flag lost without clear");
    chk_global_read: assert property (reg_rd && reg_addr == `SWEC_ADDR_GLOBAL |=>
        reg_rdata[0] == $past(sys_event_pending) && (reg_rdata != 8'h00) == $past(event_pending))
        else $error("global summary wrong");
    chk_sys_summary: assert property (sys_event_pending |-> event_pending)
        else $error("system event not summarised");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > `SWEC_ADDR_WAKE |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
    cov_reset_go: cover property (reset_go);
    cov_sleep_go: cover property (sleep_go);
    cov_trx_read: cover property (reg_rd && reg_addr == `SWEC_ADDR_TRX);
endmodule // swec_event_capture_monitor

bind swec_event_capture swec_event_capture_monitor #(.SILENCE_CYCLES(SILENCE_CYCLES)) mon (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .device_mode_code, .mode_wr, .mode_wdata, .sleep_go, .reset_go,
    .aux_over_det, .aux_under_det, .main_under_det, .pn_frame_err_det, .bus_activity,
    .transceiver_mode_code, .vcan_under_off, .txd_dom_clamp, .can_wake_det, .trx_offline,
    .wake_pin, .sys_event_pending, .event_pending
);

/* tb/swec_host_model.sv */
`timescale 1ns/1ps
module swec_host_model (
    // Clock
    input wire clk,
    // Register port
    output logic [6:0] reg_addr = 7'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_wdata = 8'h00,
    input wire [7:0] reg_rdata
);
    // One strobe cycle per access; data inverted after release so stale values never match
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule // swec_host_model

/* tb/swec_event_capture_tb_top.sv */
`timescale 1ns/1ps
`include "swec_consts.vh"
module swec_event_capture_tb_top;
    // Short timeout keeps the run small
    localparam [`SWEC_TIMER_W-1:0] SIL = 24'd20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire [6:0] reg_addr;
    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    logic [2:0] device_mode_code = 3'h4;
    logic mode_wr = 1'b0;
    logic [2:0] mode_wdata = 3'h0;
    wire sleep_go;
    wire reset_go;
    logic [7:0] det = 8'h00;
    logic bus_activity = 1'b0;
    logic [1:0] transceiver_mode_code = `SWEC_TRX_MODE_ACTIVE;
    logic trx_offline = 1'b1;
    logic sys_event_pending = 1'b0;
    wire event_pending;
    logic [7:0] rd_val;
    logic [7:0] rnd;
    logic [7:0] exp_f [3] = '{8'h00, 8'h00, 8'h00};
    logic [6:0] fa [3] = '{`SWEC_ADDR_SUPPLY, `SWEC_ADDR_TRX, `SWEC_ADDR_WAKE};
    logic [6:0] en_a [3] = '{`SWEC_ADDR_SUPPLY_EN, `SWEC_ADDR_TRX_EN, `SWEC_ADDR_WAKE_EN};
    logic [7:0] en_m [3] = '{`SWEC_MASK_SUPPLY, `SWEC_MASK_TRX_EN, `SWEC_MASK_WAKE};
    // Register index and flag mask for each detector
    logic [9:0] loc [8] = '{10'h004, 10'h002, 10'h001, 10'h120, 10'h102, 10'h102, 10'h101,
        10'h203};
    integer error_cnt = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer seed = 32'h9573a3b2;
    integer r;
    always #4 clk = ~clk;
    swec_event_capture #(.SILENCE_CYCLES(SIL)) DUT (
        .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .device_mode_code, .mode_wr, .mode_wdata, .sleep_go, .reset_go,
        .aux_over_det(det[0]), .aux_under_det(det[1]), .main_under_det(det[2]),
        .pn_frame_err_det(det[3]), .bus_activity, .transceiver_mode_code,
        .vcan_under_off(det[4]), .txd_dom_clamp(det[5]), .can_wake_det(det[6]),
        .trx_offline, .wake_pin(det[7]), .sys_event_pending, .event_pending
    );
    swec_host_model host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run = tests_run + 1;
        if (seen !== want) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] want);
        host.rd(a, rd_val);
        check(rd_val, want);
    endtask
    task automatic flags_chk;
        logic [7:0] g;
        g = {4'h0, exp_f[2] != 0, exp_f[1] != 0, exp_f[0] != 0, sys_event_pending};
        for (int k = 0; k < 3; k++) begin
            rd_chk(fa[k], exp_f[k]);
        end
        rd_chk(`SWEC_ADDR_GLOBAL, g);
        check({7'h00, event_pending}, {7'h00, g != 8'h00});
    endtask
    task automatic mode_chk(input logic want_reset);
        @(posedge clk);
        #1;
        mode_wr = 1'b1;
        mode_wdata = `SWEC_MODE_SLEEP;
        @(posedge clk);
        #1;
        mode_wr = 1'b0;
        mode_wdata = 3'h6;
        check({6'h00, reset_go, sleep_go}, {6'h00, want_reset, !want_reset});
    endtask
    task automatic pulse(input int i);
        repeat (2) @(posedge clk);
        #1;
        det[i] = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        det[i] = 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        host.wr(`SWEC_ADDR_GLOBAL, 8'hff);
        flags_chk();
        rd_chk(7'h7f, 8'h00);
        // Pass 0 open, pass 1 gated by mode and trx_offline low, pass 2 with enables off
        for (int p = 0; p < 3; p++) begin
            transceiver_mode_code = (p == 1) ? 2'h2 : `SWEC_TRX_MODE_ACTIVE;
            trx_offline = (p != 1);
            for (int k = 0; k < 3; k++) begin
                if (p == 0) rd_chk(en_a[k], 8'h00);
                host.wr(en_a[k], (p < 2) ? 8'hff : 8'h00);
                if (p == 0) rd_chk(en_a[k], en_m[k]);
            end
            for (int i = 0; i < 8; i++) begin
                // Bus-supply undervoltage with the device awake, so only the transceiver mode code gates it
                device_mode_code = (p == 1 && i != 4) ? `SWEC_MODE_SLEEP : 3'h4;
                pulse(i);
                r = loc[i] >> 8;
                if (p == 0 || i == 3 || (p == 1 && (i < 2 || i == 7))) exp_f[r] |= loc[i][7:0];
                flags_chk();
                if (p == 0) mode_chk(1'b1);
                rnd = $random(seed);
                host.wr(fa[r], rnd);
                exp_f[r] = exp_f[r] & ~rnd;
                rd_chk(fa[r], exp_f[r]);
                host.wr(fa[r], 8'hff);
                exp_f[r] = 8'h00;
                if (p == 0) mode_chk(1'b0);
            end
        end
        host.wr(`SWEC_ADDR_TRX_EN, 8'h10);
        @(posedge clk);
        #1;
        bus_activity = 1'b1;
        @(posedge clk);
        #1;
        bus_activity = 1'b0;
        // Reads land on the last quiet edge and just after the flag sets
        repeat (SIL - 2) @(posedge clk);
        rd_chk(`SWEC_ADDR_TRX, 8'h00);
        rd_chk(`SWEC_ADDR_TRX, 8'h10);
        host.wr(`SWEC_ADDR_TRX, 8'hff);
        repeat (SIL + 5) @(posedge clk);
        rd_chk(`SWEC_ADDR_TRX, 8'h00);
        sys_event_pending = 1'b1;
        flags_chk();
        mode_chk(1'b1);
        sys_event_pending = 1'b0;
        test_done();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            error_cnt = error_cnt + 1;
            test_done();
        end
    end
endmodule // swec_event_capture_tb_top
